// file: logic/pdq_pkg.sv
package pdq_pkg;

    // APB register offsets (byte addresses)
    localparam logic [7:0] PDQ_CTRL_OFS   = 8'h00;
    localparam logic [7:0] PDQ_STAT_OFS   = 8'h04;
    localparam logic [7:0] PDQ_MR3_OFS    = 8'h08;
    localparam logic [7:0] PDQ_MRS_OFS    = 8'h0c;
    localparam logic [7:0] PDQ_TIME_OFS   = 8'h10;

    // Mode register field positions
    localparam int MR3_PDA_BIT      = 4;
    localparam int MR1_NOM_LSB      = 8;
    localparam int MR1_NOM_MSB      = 10;
    localparam int MR5_PARK_LSB     = 6;
    localparam int MR5_PARK_MSB     = 8;
    localparam int MR5_PL_LSB       = 0;
    localparam int MR5_PL_MSB       = 2;

    // Reset values
    localparam logic [17:0] MR_RESET = 18'h00000;
    localparam logic [7:0]  AL_RESET = 8'h00;
    localparam logic [7:0]  CWL_RESET = 8'h09;

    // Parity latency encodings to clocks
    localparam logic [3:0] PL_OFF  = 4'h0;
    localparam logic [3:0] PL_ENC1 = 4'h4;
    localparam logic [3:0] PL_ENC2 = 4'h5;
    localparam logic [3:0] PL_ENC3 = 4'h6;
    localparam logic [3:0] PL_ENC4 = 4'h8;

    // Capture waits in DQS beats: every strobe edge counts; the first edge of either direction is beat 1, the next is beat 2
    localparam logic [3:0] BEAT_FIRST_FALL = 4'h1;
    localparam logic [3:0] BEAT_BC4 = 4'h4;
    localparam logic [3:0] BEAT_BL8 = 4'h8;

    typedef enum logic [1:0] {
        PDQ_IDLE = 2'b00,
        PDQ_WAIT = 2'b01,
        PDQ_CAPT = 2'b10,
        PDQ_DONE = 2'b11
    } pdq_state_e;

    // A mode register set command as seen on the command bus
    typedef struct packed {
        logic        valid;
        logic [2:0]  mr;
        logic [17:0] data;
        logic        chop;
    } pdq_cmd_s;

    typedef struct packed {
        logic       dqs;
        logic       dq0;
    } pdq_link_s;

    function automatic logic [3:0] pl_clocks(input logic [2:0] enc);
        case (enc)
            3'h1:    return PL_ENC1;
            3'h2:    return PL_ENC2;
            3'h3:    return PL_ENC3;
            3'h4:    return PL_ENC4;
            default: return PL_OFF;
        endcase
    endfunction : pl_clocks

endpackage : pdq_pkg

// file: logic/pdq_qual.sv
`timescale 1ns/100ps
// Watches the synchronised strobe and takes DQ0 on its first edge, rising or falling.
module pdq_qual
    import pdq_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic chop,
    input  wire logic dqs,
    input  wire logic dq0,
    output logic      done,
    output logic      level
);
    logic [3:0] beat_q, beat_d;
    logic       busy_q, busy_d;
    logic       lvl_q, lvl_d;
    logic       done_q, done_d;
    logic       dqs_q;

    always_comb begin
        beat_d = beat_q;
        busy_d = busy_q;
        lvl_d  = lvl_q;
        done_d = 1'b0;
        if (start) begin
            busy_d = 1'b1;
            beat_d = 4'h0;
        end else if (busy_q && (dqs != dqs_q)) begin
            beat_d = beat_q + 4'h1;
            if (beat_q + 4'h1 == BEAT_FIRST_FALL) begin
                lvl_d = dq0;
            end
            if (beat_q + 4'h1 == (chop ? BEAT_BC4 : BEAT_BL8)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            beat_q <= 4'h0;
            busy_q <= 1'b0;
            lvl_q  <= 1'b1;
            done_q <= 1'b0;
            dqs_q  <= 1'b0;
        end else begin
            beat_q <= beat_d;
            busy_q <= busy_d;
            lvl_q  <= lvl_d;
            done_q <= done_d;
            dqs_q  <= dqs;
        end
    end

    assign done  = done_q;
    assign level = lvl_q;

    capture_edge_a: assert property (@(posedge clk) disable iff (rst)
        busy_q && beat_q == 4'h0 && dqs != dqs_q |=> lvl_q == $past(dq0))
        else $error("qualifier not taken on first strobe edge");
endmodule : pdq_qual

// file: logic/pdq_top.sv
`timescale 1ns/100ps
// Summary of operation
// - The qualifier on DQ0 is sampled on the first strobe edge of the burst, rising or falling.
// - Both chop-4 and length-8 bursts, fixed or on the fly, are accepted.
// - Park and nominal termination may stay enabled across entry.
// - The mode starts when MR3 bit 4 is written to 1; it resets to 0.
// - In the mode a register set executes only if DQ0 was low, else is dropped.
// - DQ0 passes a two-flop synchroniser and is sampled on CLK when the synchronised strobe toggles.
// - Clearing MR3 bit 4 with DQ0 low leaves the mode on every device.
// - No dynamic termination switching on the qualifying transfers.
// - With nominal termination on, termination follows the ODT pin.
// - PL is 0 with parity off or encodings 5 to 7, else 4, 5, 6 or 8 clocks.
module pdq_top
    import pdq_pkg::*;
#(
    parameter int SET_DELAY = 24
)(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        MRS_VALID,
    input  wire logic [2:0]  MRS_REG,
    input  wire logic [17:0] MRS_DATA,
    input  wire logic        MRS_CHOP,
    input  wire logic        DQS,
    input  wire logic        DQ0,
    input  wire logic        ODT,
    output logic             MODE_ON,
    output logic             TERM_EN,
    output logic             DYN_TERM_EN
);
    initial begin
        if (SET_DELAY < 1 || SET_DELAY > 255) begin
            $error("SET_DELAY out of range");
        end
    end

    // Two-flop synchronisers for pins
    logic [1:0] dqs_s, dq0_s, odt_s;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dqs_s <= 2'b00;
            dq0_s <= 2'b11;
            odt_s <= 2'b00;
        end else begin
            dqs_s <= {dqs_s[0], DQS};
            dq0_s <= {dq0_s[0], DQ0};
            odt_s <= {odt_s[0], ODT};
        end
    end

    logic [17:0] mr_q [0:7];
    logic [17:0] mr_d [0:7];
    pdq_cmd_s    cmd_q, cmd_d;
    pdq_state_e  st_q, st_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        perr_q, perr_d;
    logic        exec_q, exec_d;
    logic        drop_q, drop_d;
    logic [7:0]  al_q, al_d;
    logic [7:0]  cwl_q, cwl_d;
    logic [9:0]  gap_q, gap_d;
    logic        gap_viol_q, gap_viol_d;
    logic        term_q, term_d;
    logic [7:0]  ndrop_q, ndrop_d;
    logic        q_start;
    logic        q_done;
    logic        q_level;

    pdq_qual u_qual (
        .clk   (CLK),
        .rst   (RST),
        .start (q_start),
        .chop  (cmd_q.chop),
        .dqs   (dqs_s[1]),
        .dq0   (dq0_s[1]),
        .done  (q_done),
        .level (q_level)
    );

    wire logic pda_on = mr_q[3][MR3_PDA_BIT];
    wire logic apb_wr = PSEL && PENABLE && PWRITE && !pready_q;
    wire logic apb_rd = PSEL && PENABLE && !PWRITE && !pready_q;

    // Command gap in clocks: AL + CWL + burst length / 2 (2 or 4) + SET_DELAY + PL
    function automatic logic [9:0] min_gap(input logic [7:0] al, input logic [7:0] cwl,
                                           input logic chop, input logic [2:0] pl_enc);
        logic [9:0] bl_half;
        bl_half = chop ? 10'h002 : 10'h004;
        return {2'b00, al} + {2'b00, cwl} + bl_half + 10'(SET_DELAY)
               + {6'h00, pl_clocks(pl_enc)};
    endfunction : min_gap

    assign q_start = (st_q == PDQ_IDLE) && MRS_VALID && pda_on;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            mr_d[i] = mr_q[i];
        end
        cmd_d      = cmd_q;
        st_d       = st_q;
        exec_d     = 1'b0;
        drop_d     = 1'b0;
        gap_d      = (gap_q != 10'h000) ? gap_q - 10'h001 : gap_q;
        gap_viol_d = gap_viol_q;
        ndrop_d    = ndrop_q;
        case (st_q)
            PDQ_IDLE: begin
                if (MRS_VALID) begin
                    if (pda_on && gap_q != 10'h000) begin
                        gap_viol_d = 1'b1;
                    end
                    if (pda_on) begin
                        cmd_d = '{valid: 1'b1, mr: MRS_REG, data: MRS_DATA, chop: MRS_CHOP};
                        st_d  = PDQ_WAIT;
                        gap_d = min_gap(al_q, cwl_q, MRS_CHOP, mr_q[5][MR5_PL_MSB:MR5_PL_LSB]);
                    end else begin
                        mr_d[MRS_REG] = MRS_DATA;
                        exec_d = 1'b1;
                    end
                end
            end
            PDQ_WAIT: begin
                if (q_done) begin
                    st_d = PDQ_DONE;
                end
            end
            PDQ_DONE: begin
                // execute on low, drop on high
                if (!q_level) begin
                    mr_d[cmd_q.mr] = cmd_q.data;
                    exec_d = 1'b1;
                end else begin
                    drop_d  = 1'b1;
                    ndrop_d = ndrop_q + 8'h01;
                end
                cmd_d.valid = 1'b0;
                st_d = PDQ_IDLE;
            end
            default: st_d = PDQ_IDLE;
        endcase
        if (apb_wr && PADDR == PDQ_STAT_OFS) begin
            gap_viol_d = 1'b0;
            ndrop_d    = 8'h00;
        end
    end

    always_comb begin
        al_d     = al_q;
        cwl_d    = cwl_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        perr_d   = 1'b0;
        if (apb_wr || apb_rd) begin
            pready_d = 1'b1;
            prdata_d = 32'h00000000;
            if (PADDR == PDQ_CTRL_OFS) begin
                if (apb_wr) begin
                    al_d  = PWDATA[7:0];
                    cwl_d = PWDATA[15:8];
                end
                prdata_d = {16'h0000, cwl_q, al_q};
            end else if (PADDR == PDQ_STAT_OFS) begin
                prdata_d = {14'h0000, ndrop_q, 5'h00, gap_viol_q, st_q, term_q, pda_on};
            end else if (PADDR == PDQ_MR3_OFS) begin
                prdata_d = {14'h0000, mr_q[3]};
            end else if (PADDR == PDQ_MRS_OFS) begin
                prdata_d = {12'h000, cmd_q.valid, cmd_q.mr, cmd_q.data[15:0]};
            end else if (PADDR == PDQ_TIME_OFS) begin
                prdata_d = {22'h000000, gap_q};
            end else begin
                perr_d = 1'b1;
            end
        end
    end

    // park and nominal may stay enabled
    always_comb begin
        term_d = (mr_q[1][MR1_NOM_MSB:MR1_NOM_LSB] != 3'h0) ? odt_s[1]
               : (mr_q[5][MR5_PARK_MSB:MR5_PARK_LSB] != 3'h0);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                mr_q[i] <= MR_RESET;
            end
            cmd_q      <= '0;
            st_q       <= PDQ_IDLE;
            prdata_q   <= 32'h00000000;
            pready_q   <= 1'b0;
            perr_q     <= 1'b0;
            exec_q     <= 1'b0;
            drop_q     <= 1'b0;
            al_q       <= AL_RESET;
            cwl_q      <= CWL_RESET;
            gap_q      <= 10'h000;
            gap_viol_q <= 1'b0;
            term_q     <= 1'b0;
            ndrop_q    <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                mr_q[i] <= mr_d[i];
            end
            cmd_q      <= cmd_d;
            st_q       <= st_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            perr_q     <= perr_d;
            exec_q     <= exec_d;
            drop_q     <= drop_d;
            al_q       <= al_d;
            cwl_q      <= cwl_d;
            gap_q      <= gap_d;
            gap_viol_q <= gap_viol_d;
            term_q     <= term_d;
            ndrop_q    <= ndrop_d;
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = perr_q;
    assign MODE_ON = mr_q[3][MR3_PDA_BIT];
    assign TERM_EN = term_q;
    // dynamic termination off in the mode
    assign DYN_TERM_EN = 1'b0;

    drop_no_write_a: assert property (@(posedge CLK) disable iff (RST)
        st_q == PDQ_DONE && q_level |=> mr_q[cmd_q.mr] == $past(mr_q[cmd_q.mr]))
        else $error("dropped command changed a register");
    exec_on_low_a: assert property (@(posedge CLK) disable iff (RST)
        st_q == PDQ_DONE && !q_level |=> exec_q && !drop_q)
        else $error("qualified command not executed");
    entry_bit_a: assert property (@(posedge CLK) disable iff (RST)
        st_q == PDQ_IDLE && MRS_VALID && !pda_on && MRS_REG == 3'h3
        && MRS_DATA[MR3_PDA_BIT] |=> MODE_ON)
        else $error("mode not entered");
    exit_bit_a: assert property (@(posedge CLK) disable iff (RST)
        st_q == PDQ_DONE && !q_level && cmd_q.mr == 3'h3
        && !cmd_q.data[MR3_PDA_BIT] |=> !MODE_ON)
        else $error("mode not left");
    burst_end_a: assert property (@(posedge CLK) disable iff (RST)
        st_q == PDQ_WAIT && q_done |=> st_q == PDQ_DONE ##1 st_q == PDQ_IDLE)
        else $error("burst not completed");
    gap_load_a: assert property (@(posedge CLK) disable iff (RST)
        q_start |=> gap_q >= 10'(SET_DELAY) + 10'h002)
        else $error("command gap not loaded");
    no_dyn_term_a: assert property (@(posedge CLK) disable iff (RST)
        MODE_ON |-> !DYN_TERM_EN)
        else $error("dynamic termination in mode");
    odt_follow_a: assert property (@(posedge CLK) disable iff (RST)
        mr_q[1][MR1_NOM_MSB:MR1_NOM_LSB] != 3'h0 && $stable(mr_q[1])
        |=> TERM_EN == $past(odt_s[1]))
        else $error("termination not following pin");
    pl_value_a: assert property (@(posedge CLK) disable iff (RST)
        q_start && mr_q[5][MR5_PL_MSB:MR5_PL_LSB] == 3'h0
        |=> gap_q == {2'b00, $past(al_q)} + {2'b00, $past(cwl_q)}
                     + ($past(MRS_CHOP) ? 10'h002 : 10'h004) + 10'(SET_DELAY))
        else $error("parity latency not zero");
endmodule : pdq_top

// file: sim/pdq_ctrl_model.sv
`timescale 1ns/100ps
// Memory controller side: mode register set commands plus the strobed qualifier
module pdq_ctrl_model
    import pdq_pkg::*;
(
    input  wire logic        clk,
    output logic             mrs_valid,
    output logic [2:0]       mrs_reg,
    output logic [17:0]      mrs_data,
    output logic             mrs_chop,
    output logic             dqs,
    output logic             dq0
);
    initial begin
        mrs_valid = 1'b0;
        mrs_reg   = 3'h0;
        mrs_data  = 18'h00000;
        mrs_chop  = 1'b0;
        dqs       = 1'b0;
        dq0       = 1'b1;
    end

    task automatic send(input logic [2:0] r, input logic [17:0] d, input logic c,
                        input logic burst, input logic q);
        @(posedge clk);
        mrs_valid <= 1'b1;
        mrs_reg   <= r;
        mrs_data  <= d;
        mrs_chop  <= c;
        @(posedge clk);
        mrs_valid <= 1'b0;
        if (burst) begin
            // only DQ0 is wired; every DQ bit would carry this level
            dq0 <= q;
            repeat (c ? 4 : 8) begin
                repeat (4) @(posedge clk);
                dqs <= ~dqs;
            end
            repeat (4) @(posedge clk);
            // Released line has no pull, so show the opposite level
            dq0 <= ~q;
        end
    endtask : send
endmodule : pdq_ctrl_model

// file: sim/pdq_top_test.sv
`timescale 1ns/100ps
module pdq_top_test
    import pdq_pkg::*;
;
    localparam int SET_DLY = 4;

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mrs_valid;
    logic [2:0]  mrs_reg;
    logic [17:0] mrs_data;
    logic        mrs_chop;
    logic        dqs;
    logic        dq0;
    logic        odt;
    logic        mode_on;
    logic        term_en;
    logic        dyn_term_en;
    logic [31:0] rd;
    logic        err;
    logic [31:0] prev;
    int          n_fail;
    int          checks;
    int          cyc;

    always #10 clk = ~clk;

    pdq_top #(.SET_DELAY(SET_DLY)) DUT (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MRS_VALID(mrs_valid), .MRS_REG(mrs_reg),
        .MRS_DATA(mrs_data), .MRS_CHOP(mrs_chop), .DQS(dqs), .DQ0(dq0), .ODT(odt),
        .MODE_ON(mode_on), .TERM_EN(term_en), .DYN_TERM_EN(dyn_term_en));

    pdq_ctrl_model ctl (
        .clk(clk), .mrs_valid(mrs_valid), .mrs_reg(mrs_reg), .mrs_data(mrs_data),
        .mrs_chop(mrs_chop), .dqs(dqs), .dq0(dq0));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k == 50) n_fail++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_term(input logic v);
        int k;
        k = 0;
        while (term_en !== v && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk(term_en, v);
    endtask : wait_term

    task automatic test_done;
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        odt = 1'b0;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        apb(1'b0, PDQ_CTRL_OFS, 32'h0);
        chk(rd, {16'h0000, CWL_RESET, AL_RESET});
        apb(1'b0, PDQ_MR3_OFS, 32'h0);
        chk(rd, 32'h00000000);
        chk(mode_on, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1'b1);
        // write leveling taken as done before entry
        ctl.send(3'h1, 18'h00100, 1'b0, 1'b0, 1'b0);
        ctl.send(3'h3, 18'h00010, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk(mode_on, 1'b1);
        apb(1'b0, PDQ_MR3_OFS, 32'h0);
        chk(rd, 32'h00000010);
        odt <= 1'b1;
        wait_term(1'b1);
        odt <= 1'b0;
        wait_term(1'b0);
        prev = 32'h00000010;
        // Low qualifier executes, high one drops, for both burst lengths
        for (int i = 0; i < 4; i++) begin
            ctl.send(3'h3, 18'h00010 | 18'(i), i[1], 1'b1, i[0]);
            chk(dyn_term_en, 1'b0);
            repeat (8) @(posedge clk);
            apb(1'b0, PDQ_MR3_OFS, 32'h0);
            if (!i[0]) prev = 32'h00000010 | 32'(i);
            chk(rd, prev);
        end
        apb(1'b0, PDQ_STAT_OFS, 32'h0);
        chk(rd[17:10], 8'h02);
        chk(rd[4], 1'b0);
        apb(1'b1, PDQ_CTRL_OFS, 32'h000009ff);
        ctl.send(3'h3, 18'h00012, 1'b0, 1'b1, 1'b1);
        repeat (8) @(posedge clk);
        // Second command well inside the long gap
        ctl.send(3'h3, 18'h00012, 1'b0, 1'b1, 1'b1);
        repeat (8) @(posedge clk);
        apb(1'b0, PDQ_STAT_OFS, 32'h0);
        chk(rd[4], 1'b1);
        apb(1'b1, PDQ_STAT_OFS, 32'h0);
        apb(1'b0, PDQ_STAT_OFS, 32'h0);
        chk({rd[17:10], rd[4]}, 9'h000);
        apb(1'b1, PDQ_CTRL_OFS, 32'h00000900);
        repeat (300) @(posedge clk);
        ctl.send(3'h3, 18'h00003, 1'b0, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        chk(mode_on, 1'b0);
        apb(1'b0, PDQ_MR3_OFS, 32'h0);
        chk(rd, 32'h00000003);
        chk(dyn_term_en, 1'b0);
        test_done();
    end
endmodule : pdq_top_test
